// ==== rcas_arbiter_status.sv ====
// Purpose: coexistence arbiter core with its two read-only status registers on apb
// Assumes: all inputs synchronous to core_clk; priority table lookup sits outside
// Notes: the apb answer comes in the first access cycle; writes are accepted and ignored
//
// Notes on behaviour
// R1 - the link-core activity used for decisions is the link-ignore bit ANDed with the core's event-in-process.
// R2 - the outside activity used for decisions is the outside-ignore bit ANDed with the combined outside request.
// R3 - radio busy is the OR of all radio sub-functions, reported live and used by the arbiter one cycle late.
// R4 - status bits 11 to 8 show live the two request pins and the on-chip priority and activity pins.
// R5 - status bit 7 shows whether the arbiter sits in its winding-down substate.
// R6 - the grant code is 0 for none, 1 for the link core, 3 for the outside mac, and 2 is never produced.
// R7 - while the grant is none every mac is denied the radio and the priority pin stays low.
// R8 - in priority programming mode the priority entries are invalid and no new decision is taken.
// R9 - the grant stays none while no activity is asserted, and in programming mode once the transaction ends.
// R10 - a four-bit field shows the winning priority index, 0 meaning no entry.
// R11 - second status bit 15 shows the outside activity used by the decision logic.
// R12 - second status bits 14 to 12 show the packet type used by the decision logic.
// R13 - second status bits 11 and 10 show the link core's transmit and receive enables.
// R14 - second status bit 9 shows the link-core activity used by the decision logic.
// R15 - the combined outside request is the OR of the two request pins.
// R16 - writes to the status registers do nothing, reads have no side effect, and all registered fields reset to 0; fields fed live from inputs follow them.
`timescale 1ns/1ps
module rcas_arbiter_status
	import rcas_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter int SUB_FUNCS = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// control levels from the arbiter control register
	input wire logic ignoreLinkStat,
	input wire logic ignoreOutsideStat,
	input wire logic programmingMode,
	// outside wireless mac
	input wire logic outsideRequestPinA,
	input wire logic outsideRequestPinB,
	output logic onchipPriorityOut,
	output logic onchipActivityOut,
	// on-chip link-layer core
	input wire logic linkEventInProcess,
	input wire logic [2:0] packetTypeIndicator,
	input wire logic linkCoreTransmitOn,
	input wire logic linkCoreReceiveOn,
	output logic linkCoreGrant,
	// radio
	input wire logic [SUB_FUNCS-1:0] radioSubFunctionBusy,
	output logic outsideMacGrant,
	// priority table lookup
	input wire logic [3:0] priorityMatchIndex,
	input wire logic outsideWinsPriority
);

	rcas_regs_t state_reg;
	rcas_regs_t state_next;

	logic combinedOutsideReq;
	logic linkActiveNow;
	logic outsideActiveNow;
	logic radioInUseState;
	logic [15:0] statusWord;
	logic [15:0] statusTwoWord;
	logic setupPhase;

	// refuse parameter values that the decode or the busy merge cannot serve
	if (ADDR_W < 14 || ADDR_W > 32) begin : g_bad_addr_w
		$error("rcas_arbiter_status: ADDR_W must lie between 14 and 32");
	end
	if (SUB_FUNCS < 1) begin : g_bad_sub_funcs
		$error("rcas_arbiter_status: SUB_FUNCS must be at least 1");
	end

	// decode of a register byte address against the low address bits seen by this slave
	function automatic logic addrHits(input logic [ADDR_W-1:0] addr, input logic [31:0] byteAddr);
		addrHits = (addr[ADDR_W-1:2] == byteAddr[ADDR_W-1:2]);
	endfunction

	assign combinedOutsideReq = outsideRequestPinA | outsideRequestPinB; // R15
	assign linkActiveNow = ignoreLinkStat & linkEventInProcess; // R1
	assign outsideActiveNow = ignoreOutsideStat & combinedOutsideReq; // R2
	assign radioInUseState = |radioSubFunctionBusy; // R3
	assign setupPhase = psel & ~penable;

	always_comb begin
		statusWord = 16'h0000;
		statusWord[RCAS_ST_IGNORE_LINK] = ignoreLinkStat;
		statusWord[RCAS_ST_IGNORE_OUTSIDE] = ignoreOutsideStat;
		statusWord[RCAS_ST_RADIO_IN_USE] = radioInUseState; // R3
		statusWord[RCAS_ST_REQ_PIN_B] = outsideRequestPinB; // R4
		statusWord[RCAS_ST_REQ_PIN_A] = outsideRequestPinA; // R4
		statusWord[RCAS_ST_PRIORITY_OUT] = state_reg.priorityOut; // R4
		statusWord[RCAS_ST_ACTIVITY_OUT] = state_reg.activityOut; // R4
		statusWord[RCAS_ST_WINDING_DOWN] = (state_reg.arbState == RCAS_WINDING_DOWN); // R5
		statusWord[RCAS_ST_GRANT_LSB +: 2] = state_reg.grantCode; // R6
		statusWord[RCAS_ST_INDEX_LSB +: 4] = state_reg.winIndex; // R10
	end

	always_comb begin
		statusTwoWord = 16'h0000;
		statusTwoWord[RCAS_ST2_OUTSIDE_USED] = state_reg.outsideUsed; // R11
		statusTwoWord[RCAS_ST2_PTYPE_LSB +: 3] = state_reg.packetTypeUsed; // R12
		statusTwoWord[RCAS_ST2_TX_ON] = linkCoreTransmitOn; // R13
		statusTwoWord[RCAS_ST2_RX_ON] = linkCoreReceiveOn; // R13
		statusTwoWord[RCAS_ST2_LINK_USED] = state_reg.linkUsed; // R14
	end

	always_comb begin
		state_next = state_reg;

		// activity and busy as seen by the decision logic
		state_next.linkUsed = linkActiveNow; // R14
		state_next.outsideUsed = outsideActiveNow; // R11
		state_next.radioBusyLate = radioInUseState; // R3

		// packet type is taken when link activity rises and held for the transaction
		if (linkActiveNow && !state_reg.linkUsed) begin
			state_next.packetTypeUsed = packetTypeIndicator; // R12
		end

		unique case (state_reg.arbState)
			RCAS_IDLE: begin
				// no decision while programming or while nothing is active
				if (!programmingMode) begin // R8
					if (state_reg.outsideUsed && (!state_reg.linkUsed || outsideWinsPriority)) begin
						state_next.arbState = RCAS_OUTSIDE_OWNS;
						state_next.grantCode = RCAS_GRANT_OUTSIDE; // R6
						state_next.winIndex = priorityMatchIndex; // R10
					end else if (state_reg.linkUsed) begin
						state_next.arbState = RCAS_LINK_OWNS;
						state_next.grantCode = RCAS_GRANT_LINK; // R6
						state_next.winIndex = priorityMatchIndex; // R10
					end else begin
						state_next.grantCode = RCAS_GRANT_NONE; // R9
					end
				end else begin
					state_next.grantCode = RCAS_GRANT_NONE; // R9
				end
			end
			RCAS_LINK_OWNS: begin
				// the ongoing transaction completes even in programming mode
				if (!state_reg.linkUsed) begin
					state_next.arbState = RCAS_WINDING_DOWN; // R5
				end
			end
			RCAS_OUTSIDE_OWNS: begin
				if (!state_reg.outsideUsed) begin
					state_next.arbState = RCAS_WINDING_DOWN; // R5
				end
			end
			RCAS_WINDING_DOWN: begin
				// wait for the radio to go quiet, seen one cycle late
				if (!state_reg.radioBusyLate) begin // R3
					state_next.arbState = RCAS_IDLE;
					state_next.grantCode = RCAS_GRANT_NONE; // R9
				end
			end
		endcase

		// grants and the priority pin follow the decision, the activity pin follows link activity; none denies every mac
		state_next.linkGrant = (state_next.grantCode == RCAS_GRANT_LINK); // R7
		state_next.outsideGrant = (state_next.grantCode == RCAS_GRANT_OUTSIDE); // R7
		state_next.priorityOut = (state_next.grantCode == RCAS_GRANT_LINK); // R7
		state_next.activityOut = linkActiveNow;

		// apb: answer in the first access cycle, writes ignored, reads side-effect free
		state_next.ready = setupPhase;
		state_next.slvErr = 1'b0;
		state_next.rdata = RCAS_RDATA_RESET;
		if (setupPhase) begin
			if (addrHits(paddr, RCAS_ADDR_ARBITER_STATUS)) begin
				if (!pwrite) begin // R16
					state_next.rdata = {16'h0000, statusWord};
				end
			end else if (addrHits(paddr, RCAS_ADDR_ARBITER_STATUS_TWO)) begin
				if (!pwrite) begin // R16
					state_next.rdata = {16'h0000, statusTwoWord};
				end
			end else begin
				state_next.slvErr = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg.arbState <= RCAS_IDLE;
			state_reg.grantCode <= RCAS_GRANT_NONE; // R16
			state_reg.winIndex <= RCAS_INDEX_NULL;
			state_reg.linkUsed <= 1'b0;
			state_reg.outsideUsed <= 1'b0;
			state_reg.radioBusyLate <= 1'b0;
			state_reg.packetTypeUsed <= RCAS_PTYPE_RESET;
			state_reg.priorityOut <= 1'b0;
			state_reg.activityOut <= 1'b0;
			state_reg.linkGrant <= 1'b0;
			state_reg.outsideGrant <= 1'b0;
			state_reg.rdata <= RCAS_RDATA_RESET;
			state_reg.ready <= 1'b0;
			state_reg.slvErr <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata = state_reg.rdata;
	assign pready = state_reg.ready;
	assign pslverr = state_reg.slvErr;
	assign onchipPriorityOut = state_reg.priorityOut;
	assign onchipActivityOut = state_reg.activityOut;
	assign linkCoreGrant = state_reg.linkGrant;
	assign outsideMacGrant = state_reg.outsideGrant;

endmodule

// ==== rcas_arbiter_status_chk.sv ====
// Purpose: port assertions for the arbiter status block
// Assumes: one clock domain, reset active high
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module rcas_arbiter_status_chk (
	// apb side
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	// control levels and pins
	input wire logic ignoreLinkStat,
	input wire logic ignoreOutsideStat,
	input wire logic programmingMode,
	input wire logic outsideRequestPinA,
	input wire logic outsideRequestPinB,
	input wire logic linkEventInProcess,
	input wire logic onchipPriorityOut,
	input wire logic onchipActivityOut,
	input wire logic linkCoreGrant,
	input wire logic outsideMacGrant
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence apbSetup;
		psel && !penable;
	endsequence
	sequence anyGrantRise;
		$rose(linkCoreGrant || outsideMacGrant);
	endsequence
	grant_exclusive_a: assert property (!(linkCoreGrant && outsideMacGrant))
		else $error("both grants high");
	priority_link_a: assert property (onchipPriorityOut == linkCoreGrant)
		else $error("priority pin apart from link grant");
	activity_late_a: assert property (!$past(rst) |-> onchipActivityOut == $past(ignoreLinkStat && linkEventInProcess))
		else $error("activity pin wrong");
	link_cause_a: assert property ($rose(linkCoreGrant) |-> $past(ignoreLinkStat && linkEventInProcess, 2))
		else $error("link grant without request");
	outside_cause_a: assert property ($rose(outsideMacGrant) |-> $past(ignoreOutsideStat && (outsideRequestPinA || outsideRequestPinB), 2))
		else $error("outside grant without request");
	program_hold_a: assert property (anyGrantRise |-> !$past(programmingMode))
		else $error("decision during programming");
	apb_answer_a: assert property (apbSetup |=> pready)
		else $error("apb answer late");
	upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0)
		else $error("upper read half not zero");
	unmapped_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error answer carries data");
endmodule
bind rcas_arbiter_status rcas_arbiter_status_chk u_rcas_arbiter_status_chk (.core_clk, .rst, .psel, .penable,
	.pready, .pslverr, .prdata, .ignoreLinkStat, .ignoreOutsideStat, .programmingMode, .outsideRequestPinA,
	.outsideRequestPinB, .linkEventInProcess, .onchipPriorityOut, .onchipActivityOut, .linkCoreGrant, .outsideMacGrant);

// ==== rcas_far_side.sv ====
// Purpose: outside mac and link core pins facing the block
// Assumes: bench commands, levels registered on core_clk
// Notes: one radio sub-function is busy while any party holds a transaction
`timescale 1ns/1ps
module rcas_far_side (
	// clock, reset, bench commands
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [1:0] outsideCmd,
	input wire logic linkCmd,
	// pins toward the block
	output logic outsideRequestPinA,
	output logic outsideRequestPinB,
	output logic linkEventInProcess,
	output logic [3:0] radioSubFunctionBusy
);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			{outsideRequestPinB, outsideRequestPinA, linkEventInProcess, radioSubFunctionBusy} <= 7'h00;
		end else begin
			{outsideRequestPinB, outsideRequestPinA} <= outsideCmd;
			linkEventInProcess <= linkCmd;
			radioSubFunctionBusy <= {3'h0, linkCmd | (|outsideCmd)};
		end
	end
endmodule

// ==== rcas_pkg.sv ====
// Purpose: constants and types shared by the coexistence arbiter status block
// Assumes: apb slave with 32-bit data, 16-bit registers in the low half of the word
// Notes: printed offsets are register indices; byte address is four times the index
package rcas_pkg;

	// register indices as printed, byte address is index times four
	localparam logic [31:0] RCAS_IDX_ARBITER_STATUS = 32'h50002F02;
	localparam logic [31:0] RCAS_IDX_ARBITER_STATUS_TWO = 32'h50002F04;
	localparam logic [31:0] RCAS_ADDR_ARBITER_STATUS = RCAS_IDX_ARBITER_STATUS << 2;
	localparam logic [31:0] RCAS_ADDR_ARBITER_STATUS_TWO = RCAS_IDX_ARBITER_STATUS_TWO << 2;
	localparam int RCAS_REG_WIDTH = 16;

	// arbiter_status field positions
	localparam int RCAS_ST_IGNORE_LINK = 15;
	localparam int RCAS_ST_IGNORE_OUTSIDE = 13;
	localparam int RCAS_ST_RADIO_IN_USE = 12;
	localparam int RCAS_ST_REQ_PIN_B = 11;
	localparam int RCAS_ST_REQ_PIN_A = 10;
	localparam int RCAS_ST_PRIORITY_OUT = 9;
	localparam int RCAS_ST_ACTIVITY_OUT = 8;
	localparam int RCAS_ST_WINDING_DOWN = 7;
	localparam int RCAS_ST_GRANT_LSB = 5;
	localparam int RCAS_ST_INDEX_LSB = 0;

	// arbiter_status_two field positions
	localparam int RCAS_ST2_OUTSIDE_USED = 15;
	localparam int RCAS_ST2_PTYPE_LSB = 12;
	localparam int RCAS_ST2_TX_ON = 11;
	localparam int RCAS_ST2_RX_ON = 10;
	localparam int RCAS_ST2_LINK_USED = 9;

	// grant owner codes, 2'h2 is never produced
	localparam logic [1:0] RCAS_GRANT_NONE = 2'h0;
	localparam logic [1:0] RCAS_GRANT_LINK = 2'h1;
	localparam logic [1:0] RCAS_GRANT_OUTSIDE = 2'h3;

	// reset values
	localparam logic [3:0] RCAS_INDEX_NULL = 4'h0;
	localparam logic [2:0] RCAS_PTYPE_RESET = 3'h0;
	localparam logic [31:0] RCAS_RDATA_RESET = 32'h0;

	typedef enum logic [1:0] {
		RCAS_IDLE,
		RCAS_LINK_OWNS,
		RCAS_OUTSIDE_OWNS,
		RCAS_WINDING_DOWN
	} rcas_state_t;

	typedef struct packed {
		rcas_state_t arbState;
		logic [1:0] grantCode;
		logic [3:0] winIndex;
		logic linkUsed;
		logic outsideUsed;
		logic radioBusyLate;
		logic [2:0] packetTypeUsed;
		logic priorityOut;
		logic activityOut;
		logic linkGrant;
		logic outsideGrant;
		logic [31:0] rdata;
		logic ready;
		logic slvErr;
	} rcas_regs_t;

endpackage

// ==== test_radio_coexistence_arbiter_status.sv ====
// Purpose: directed test of the arbiter status block
// Assumes: apb slave answers in its own time, far side from rcas_far_side
// Notes: expected words are built by hand from the field layout
`timescale 1ns/1ps
module test_radio_coexistence_arbiter_status
	import rcas_pkg::*;
;
	localparam logic [15:0] ST = RCAS_ADDR_ARBITER_STATUS[15:0];
	localparam logic [15:0] ST2 = RCAS_ADDR_ARBITER_STATUS_TWO[15:0];
	logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, linkCmd = 1'b0;
	logic ignoreLinkStat = 1'b0, ignoreOutsideStat = 1'b0, programmingMode = 1'b0, outsideWinsPriority = 1'b0;
	logic linkCoreTransmitOn = 1'b0, linkCoreReceiveOn = 1'b0;
	logic [1:0] outsideCmd = 2'h0;
	logic [2:0] packetTypeIndicator = 3'h0;
	logic [3:0] pstrb = 4'hF, priorityMatchIndex = 4'h0, radioSubFunctionBusy;
	logic [15:0] paddr = 16'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, onchipPriorityOut, onchipActivityOut, linkCoreGrant, outsideMacGrant;
	logic outsideRequestPinA, outsideRequestPinB, linkEventInProcess;
	int errors = 0;
	int nChecks = 0;
	rcas_arbiter_status u_rcas_arbiter_status (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .ignoreLinkStat, .ignoreOutsideStat, .programmingMode, .outsideRequestPinA,
		.outsideRequestPinB, .onchipPriorityOut, .onchipActivityOut, .linkEventInProcess, .packetTypeIndicator,
		.linkCoreTransmitOn, .linkCoreReceiveOn, .linkCoreGrant, .radioSubFunctionBusy, .outsideMacGrant,
		.priorityMatchIndex, .outsideWinsPriority);
	rcas_far_side u_rcas_far_side (.core_clk, .rst, .outsideCmd, .linkCmd, .outsideRequestPinA,
		.outsideRequestPinB, .linkEventInProcess, .radioSubFunctionBusy);
	always #25 core_clk = ~core_clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		nChecks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [15:0] a, output logic [31:0] d, output logic e);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= 32'hFFFFFFFF;
		@(posedge core_clk);
		penable <= 1'b1;
		// this wait ends when pready rises, or at the watchdog
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input string what, input logic [15:0] a, input logic [31:0] m, input logic [31:0] x, input logic r);
		logic [31:0] d;
		logic e;
		apb(1'b0, a, d, e);
		chk(what, x, d & m);
		chk("pslverr", {31'h0, r}, {31'h0, e});
	endtask
	task automatic t_reset_access();
		logic [31:0] d;
		logic e;
		rd("status", ST, 32'hFFFFFFFF, 32'h0, 1'b0);
		rd("status_two", ST2, 32'hFFFFFFFF, 32'h0, 1'b0);
		apb(1'b1, ST, d, e);
		rd("status after write", ST, 32'hFFFFFFFF, 32'h0, 1'b0);
		rd("unmapped", 16'h0000, 32'hFFFFFFFF, 32'h0, 1'b1);
	endtask
	task automatic t_link_grant();
		ignoreLinkStat <= 1'b1;
		packetTypeIndicator <= 3'h5;
		linkCoreTransmitOn <= 1'b1;
		priorityMatchIndex <= 4'h9;
		linkCmd <= 1'b1;
		cyc(6);
		chk("linkCoreGrant", 32'h1, {31'h0, linkCoreGrant});
		chk("outsideMacGrant", 32'h0, {31'h0, outsideMacGrant});
		rd("link status", ST, 32'hFFFFFFFF, 32'h9329, 1'b0);
		rd("link status_two", ST2, 32'hFFFFFFFF, 32'h5A00, 1'b0);
		linkCmd <= 1'b0;
		outsideCmd <= 2'b01;
		cyc(6);
		rd("winding down", ST, 32'h0480, 32'h0480, 1'b0);
		outsideCmd <= 2'b00;
		cyc(10);
		rd("link released", ST, 32'hFFFFFFFF, 32'h8009, 1'b0);
	endtask
	task automatic t_outside_grant();
		ignoreLinkStat <= 1'b0;
		ignoreOutsideStat <= 1'b1;
		priorityMatchIndex <= 4'h3;
		outsideCmd <= 2'b10;
		cyc(6);
		rd("outside status", ST, 32'hFFFFFFFF, 32'h3863, 1'b0);
		rd("outside used", ST2, 32'h8200, 32'h8000, 1'b0);
		outsideCmd <= 2'b00;
		cyc(10);
		rd("outside released", ST, 32'h00EF, 32'h0003, 1'b0);
	endtask
	task automatic t_program_hold();
		programmingMode <= 1'b1;
		ignoreLinkStat <= 1'b1;
		linkCmd <= 1'b1;
		cyc(6);
		rd("held in programming", ST, 32'h0260, 32'h0, 1'b0);
		programmingMode <= 1'b0;
		cyc(4);
		rd("granted after programming", ST, 32'h0260, 32'h0220, 1'b0);
		linkCmd <= 1'b0;
		cyc(10);
	endtask
	task automatic t_both_active();
		ignoreOutsideStat <= 1'b1;
		outsideWinsPriority <= 1'b1;
		priorityMatchIndex <= 4'hC;
		linkCoreReceiveOn <= 1'b1;
		linkCmd <= 1'b1;
		outsideCmd <= 2'b11;
		cyc(6);
		chk("outsideMacGrant", 32'h1, {31'h0, outsideMacGrant});
		chk("linkCoreGrant", 32'h0, {31'h0, linkCoreGrant});
		rd("both status", ST, 32'h0E6F, 32'h0C6C, 1'b0);
		rd("both status_two", ST2, 32'h8E00, 32'h8E00, 1'b0);
		linkCmd <= 1'b0;
		outsideCmd <= 2'b00;
		cyc(10);
		chk("outsideMacGrant", 32'h0, {31'h0, outsideMacGrant});
		chk("linkCoreGrant", 32'h0, {31'h0, linkCoreGrant});
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", nChecks, errors);
		if (errors == 0 && nChecks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		cyc(8);
		rst <= 1'b0;
		t_reset_access();
		t_link_grant();
		t_outside_grant();
		t_program_hold();
		t_both_active();
		tally_and_finish();
	end
	initial begin
		#50000;
		errors++;
		tally_and_finish();
	end
endmodule
